// *** hdl/fpp_check_code.sv ***
`timescale 1ns/100ps
module fpp_check_code (
  // Encoder
  input wire logic [127:0] encData,
  output logic [7:0] encCode,
  // Decoder
  input wire logic [127:0] decData,
  input wire logic [7:0] decCode,
  output logic [127:0] decFixed,
  output logic dataFix,
  output logic codeFix
);

  // Data bits sit on the non power of two positions of a single error code.
  function automatic logic [7:0] nextPos(input logic [7:0] pos);
    logic [7:0] p;
    p = pos + 8'h01;
    if ((p & (p - 8'h01)) == 8'h00) begin
      p = p + 8'h01;
    end
    return p;
  endfunction

  function automatic logic [7:0] chkCalc(input logic [127:0] d);
    logic [7:0] c;
    logic [7:0] pos;
    c = 8'h00;
    pos = 8'h03;
    for (int i = 0; i < 128; i++) begin
      if (d[i]) begin
        c = c ^ pos;
      end
      pos = nextPos(pos);
    end
    return c;
  endfunction

  always_comb begin
    encCode = chkCalc(encData);
  end

  always_comb begin
    logic [7:0] syn;
    logic [7:0] pos;
    syn = chkCalc(decData) ^ decCode;
    pos = 8'h03;
    decFixed = decData;
    dataFix = 1'b0;
    codeFix = 1'b0;
    if (syn != 8'h00 && (syn & (syn - 8'h01)) == 8'h00) begin
      codeFix = 1'b1;
    end
    for (int i = 0; i < 128; i++) begin
      if (syn == pos) begin
        decFixed[i] = ~decData[i];
        dataFix = 1'b1;
      end
      pos = nextPos(pos);
    end
  end

endmodule

// *** hdl/fpp_link_if.sv ***
`timescale 1ns/100ps
interface fpp_link_if;
  logic wide;
  logic active;
  logic byteStb;
  logic [7:0] byteVal;
  logic frameEnd;
  logic aligned;
  modport rx (input wide, output active, output byteStb, output byteVal, output frameEnd, output aligned);
  modport core (output wide, input active, input byteStb, input byteVal, input frameEnd, input aligned);
endinterface

// *** hdl/fpp_link_rx.sv ***
`timescale 1ns/100ps
module fpp_link_rx (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Pins
  input wire logic sck,
  input wire logic csN,
  input wire logic [7:0] io,
  // Byte stream to the core
  fpp_link_if.rx lk
);

  logic [1:0] sckS;
  logic [1:0] csS;
  logic [7:0] ioS0;
  logic [7:0] ioS1;
  logic sckPrevQ, csPrevQ;
  logic [2:0] bitQ, bitD;
  logic [7:0] shQ, shD;
  logic stbQ, stbD, endQ, endD, alignQ, alignD;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sckS <= 2'h0;
      csS <= 2'h3;
      ioS0 <= 8'h00;
      ioS1 <= 8'h00;
    end else begin
      sckS <= {sckS[0], sck};
      csS <= {csS[0], csN};
      ioS0 <= io;
      ioS1 <= ioS0;
    end
  end

  always_comb begin
    bitD = bitQ;
    shD = shQ;
    stbD = 1'b0;
    endD = 1'b0;
    alignD = alignQ;
    if (csS[1]) begin
      // A frame that ends mid byte is flagged so the core drops it.
      bitD = 3'h0;
      if (!csPrevQ) begin
        endD = 1'b1;
        alignD = (bitQ == 3'h0);
      end
    end else if (sckS[1] && !sckPrevQ) begin
      if (lk.wide) begin
        shD = ioS1;
        stbD = 1'b1;
      end else begin
        shD = {shQ[6:0], ioS1[0]};
        bitD = bitQ + 3'h1;
        stbD = (bitQ == 3'h7);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sckPrevQ <= 1'b0;
      csPrevQ <= 1'b1;
      bitQ <= 3'h0;
      shQ <= 8'h00;
      stbQ <= 1'b0;
      endQ <= 1'b0;
      alignQ <= 1'b0;
    end else begin
      sckPrevQ <= sckS[1];
      csPrevQ <= csS[1];
      bitQ <= bitD;
      shQ <= shD;
      stbQ <= stbD;
      endQ <= endD;
      alignQ <= alignD;
    end
  end

  assign lk.active = ~csPrevQ;
  assign lk.byteStb = stbQ;
  assign lk.byteVal = shQ;
  assign lk.frameEnd = endQ;
  assign lk.aligned = alignQ;

endmodule

// *** hdl/fpp_page_program.sv ***
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/100ps
// Overview of operation
// - Every aligned 16-byte block forms one protected unit with its own check code.
// - Each unit stores 8 check bits and one correction-disabled flag.
// - First program into a unit computes and stores the code for the whole unit.
// - A later program into a used unit disables correction and sets its flag.
// - Sector erase restores data, codes and flags; only erase re-enables correction.
// - Reads of a programmed, enabled unit return single-bit corrected data.
// - Reads of a disabled unit return the stored data untouched.
// - Correction covers the whole array, OTP included, but not the registers.
// - OTP units are never erased, so a second program disables them for good.
// - A status read reports enabled state and data or code fixes per unit.
// - The page buffer holds one 512 or 1024 byte aligned page.
// - Opcode 02h takes 3 or 4 address bytes, 12h always 4, then data.
// - Data past the page end wraps to the page start.
// - A short load programs only the bytes sent and leaves the rest.
// - Busy shows in status bit 0 and a program error in bit 6.
// - Opcodes 32h and 38h take 3 or 4 address bytes, 34h 4; data 8 bits per clock.
// - Wide program marks the whole page programmed; unfilled bytes stay ones.
module fpp_page_program #(
  parameter int MEM_BYTES = 8192,
  parameter int SECTOR_BYTES = 4096,
  parameter int OTP_BYTES = 1024
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Serial link pins
  input wire logic sck,
  input wire logic csN,
  input wire logic [7:0] io,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [31:0] regRdData,
  // Status
  output logic opInProgress
);

  localparam int UNITS = MEM_BYTES / fpp_pkg::UNIT_BYTES;
  localparam int AW = $clog2(MEM_BYTES);
  localparam int UW = $clog2(UNITS);
  localparam int SEC_UNITS = SECTOR_BYTES / fpp_pkg::UNIT_BYTES;
  localparam int SECTORS = MEM_BYTES / SECTOR_BYTES;
  localparam int BUF_UNITS = fpp_pkg::PAGE_LARGE / fpp_pkg::UNIT_BYTES;
  localparam logic [UW-1:0] OTP_BASE = UW'((MEM_BYTES - OTP_BYTES) / fpp_pkg::UNIT_BYTES);
  localparam logic [UW-1:0] SEC_LAST = UW'(SEC_UNITS - 1);
  localparam logic [UW-1:0] SEC_UNITS_U = UW'(SEC_UNITS);

  if (MEM_BYTES < fpp_pkg::PAGE_LARGE || (MEM_BYTES & (MEM_BYTES - 1)) != 0 ||
      SECTOR_BYTES < fpp_pkg::PAGE_LARGE || (SECTOR_BYTES & (SECTOR_BYTES - 1)) != 0 ||
      SECTOR_BYTES > MEM_BYTES || OTP_BYTES % fpp_pkg::UNIT_BYTES != 0 || OTP_BYTES >= MEM_BYTES) begin : g_bad_size
    $error("Array, sector or OTP size cannot be served.");
  end

  fpp_link_if lk ();

  fpp_link_rx u_rx (
    .ref_clk (ref_clk),
    .rst_n (rst_n),
    .sck (sck),
    .csN (csN),
    .io (io),
    .lk (lk.rx)
  );

  fpp_pkg::fpp_state_e stateQ, stateD;
  logic [7:0] opcQ, opcD;
  logic [31:0] addrQ, addrD;
  logic [2:0] addrCntQ, addrCntD;
  logic [9:0] offQ, offD;
  logic [1:0] cntQ, cntD;
  logic wideCmdQ, wideCmdD, wideQ, wideD;
  logic latchQ, latchD, errQ, errD, busyQ, busyD;
  logic [2:0] ctrlQ, ctrlD;
  logic [AW-1:0] chkAddrQ, chkAddrD;
  logic [UW-1:0] unitQ, unitD, baseQ, baseD;
  logic [31:0] rdDataQ, rdDataD;
  logic [fpp_pkg::PAGE_LARGE-1:0] maskQ, maskD;
  logic bufWe, maskClr, memWe;

  // The array keeps no reset: software erases a sector before first use.
  logic [127:0] pageBuf [BUF_UNITS];
  logic [127:0] memData [UNITS];
  logic [7:0] memCode [UNITS];
  logic memDis [UNITS];
  logic memUsed [UNITS];

  logic [9:0] pageMask;
  logic [UW-1:0] lastUnit, memIdx, chkUnit;
  logic [15:0] unitMask;
  logic [127:0] progData, newData, memDataD, fixedData, readData;
  logic [7:0] newCode, memCodeD;
  logic memDisD, memUsedD, unitTouched, dataFix, codeFix, isProgOpc, isWideOpc, isLongOpc;

  assign lk.wide = wideQ;

  always_comb begin
    pageMask = ctrlQ[fpp_pkg::CTRL_PAGE_LARGE] ? fpp_pkg::PAGE_MASK_LARGE : fpp_pkg::PAGE_MASK_SMALL;
    lastUnit = UW'(pageMask[9:4]);
    memIdx = baseQ + unitQ;
    chkUnit = chkAddrQ[AW-1:4];
    unitMask = maskQ[{unitQ[5:0], 4'h0} +: 16];
    isWideOpc = (opcD == fpp_pkg::OPC_WPW_A) || (opcD == fpp_pkg::OPC_WPW_B) ||
                (opcD == fpp_pkg::OPC_WPW_WA);
    isProgOpc = isWideOpc || (opcD == fpp_pkg::OPC_SPW) || (opcD == fpp_pkg::OPC_SPW_WA);
    isLongOpc = (opcD == fpp_pkg::OPC_SPW_WA) || (opcD == fpp_pkg::OPC_WPW_WA) ||
                ctrlQ[fpp_pkg::CTRL_LONG_ADDR];
  end

  // Bytes not loaded program as ones, so they leave the array unchanged.
  always_comb begin
    for (int b = 0; b < fpp_pkg::UNIT_BYTES; b++) begin
      progData[b*8 +: 8] = unitMask[b] ? pageBuf[unitQ[5:0]][b*8 +: 8] : 8'hff;
    end
    newData = memData[memIdx] & progData;
    // A wide program counts every unit of the page as written.
    unitTouched = (|unitMask) || wideCmdQ;
  end

  fpp_check_code u_code (
    .encData (newData),
    .encCode (newCode),
    .decData (memData[chkUnit]),
    .decCode (memCode[chkUnit]),
    .decFixed (fixedData),
    .dataFix (dataFix),
    .codeFix (codeFix)
  );

  always_comb begin
    if (stateQ == fpp_pkg::ST_ERASE) begin
      memDataD = '1;
      memCodeD = fpp_pkg::CODE_ERASED;
      memDisD = 1'b0;
      memUsedD = 1'b0;
    end else if (!memUsed[memIdx]) begin
      memDataD = newData;
      memCodeD = newCode;
      memDisD = memDis[memIdx];
      memUsedD = 1'b1;
    end else begin
      memDataD = newData;
      memCodeD = memCode[memIdx];
      memDisD = 1'b1;
      memUsedD = 1'b1;
    end
  end

  always_comb begin
    stateD = stateQ;
    opcD = opcQ;
    addrD = addrQ;
    addrCntD = addrCntQ;
    offD = offQ;
    cntD = cntQ;
    wideCmdD = wideCmdQ;
    wideD = wideQ;
    latchD = latchQ;
    errD = errQ;
    busyD = busyQ;
    ctrlD = ctrlQ;
    chkAddrD = chkAddrQ;
    unitD = unitQ;
    baseD = baseQ;
    bufWe = 1'b0;
    maskClr = 1'b0;
    memWe = 1'b0;
    if (regWrStb) begin
      case (regAddr)
        fpp_pkg::REG_CTRL: ctrlD = regWrData[2:0];
        fpp_pkg::REG_STATUS: begin
          if (regWrData[fpp_pkg::STAT_PROG_ERR]) begin
            errD = 1'b0;
          end
        end
        fpp_pkg::REG_CHK_ADDR: chkAddrD = regWrData[AW-1:0];
        fpp_pkg::REG_ERASE: begin
          if (stateQ == fpp_pkg::ST_OPCODE && latchQ && !lk.byteStb) begin
            latchD = 1'b0;
            if (regWrData < 32'(SECTORS)) begin
              stateD = fpp_pkg::ST_ERASE;
              busyD = 1'b1;
              unitD = '0;
              baseD = UW'(regWrData[UW-1:0] * SEC_UNITS_U);
            end else begin
              errD = 1'b1;
            end
          end
        end
        default: ;
      endcase
    end
    case (stateQ)
      fpp_pkg::ST_OPCODE: begin
        if (lk.byteStb) begin
          opcD = lk.byteVal;
          cntD = 2'd1;
          stateD = fpp_pkg::ST_SKIP;
          if (isProgOpc && latchQ && (!isWideOpc || ctrlQ[fpp_pkg::CTRL_WIDE_EN])) begin
            stateD = fpp_pkg::ST_ADDR;
            addrD = 32'h0;
            addrCntD = isLongOpc ? 3'd4 : 3'd3;
            wideCmdD = isWideOpc;
          end
        end
      end
      fpp_pkg::ST_ADDR: begin
        if (lk.byteStb) begin
          addrD = {addrQ[23:0], lk.byteVal};
          addrCntD = addrCntQ - 3'd1;
          if (addrCntQ == 3'd1) begin
            stateD = fpp_pkg::ST_DATA;
            offD = {addrQ[1:0], lk.byteVal} & pageMask;
            cntD = 2'd0;
            maskClr = 1'b1;
            wideD = wideCmdQ;
          end
        end
      end
      fpp_pkg::ST_DATA: begin
        if (lk.byteStb) begin
          bufWe = 1'b1;
          offD = (offQ + 10'h001) & pageMask;
          cntD = (cntQ == 2'd2) ? 2'd2 : cntQ + 2'd1;
        end
      end
      fpp_pkg::ST_SKIP: begin
        if (lk.byteStb) begin
          cntD = 2'd2;
        end
      end
      fpp_pkg::ST_PROG: begin
        memWe = unitTouched;
        if (unitQ == lastUnit) begin
          busyD = 1'b0;
          stateD = lk.active ? fpp_pkg::ST_SKIP : fpp_pkg::ST_OPCODE;
        end else begin
          unitD = unitQ + 1'b1;
        end
      end
      fpp_pkg::ST_ERASE: begin
        memWe = (memIdx < OTP_BASE);
        if (unitQ == SEC_LAST) begin
          busyD = 1'b0;
          stateD = lk.active ? fpp_pkg::ST_SKIP : fpp_pkg::ST_OPCODE;
        end else begin
          unitD = unitQ + 1'b1;
        end
      end
      default: stateD = fpp_pkg::ST_OPCODE;
    endcase
    if (lk.frameEnd && stateQ != fpp_pkg::ST_PROG && stateQ != fpp_pkg::ST_ERASE) begin
      stateD = fpp_pkg::ST_OPCODE;
      wideD = 1'b0;
      if (stateQ == fpp_pkg::ST_SKIP && lk.aligned && opcQ == fpp_pkg::OPC_UNLOCK && cntQ == 2'd1) begin
        latchD = 1'b1;
      end
      // Frames cut mid byte or too short are dropped without programming.
      if (stateQ == fpp_pkg::ST_DATA && lk.aligned && cntQ >= (wideCmdQ ? 2'd2 : 2'd1)) begin
        latchD = 1'b0;
        if (|(addrQ >> AW)) begin
          errD = 1'b1;
        end else begin
          stateD = fpp_pkg::ST_PROG;
          busyD = 1'b1;
          unitD = '0;
          baseD = addrQ[AW-1:4] & ~lastUnit;
        end
      end
    end
  end

  always_comb begin
    maskD = maskQ;
    if (maskClr) begin
      maskD = '0;
    end else if (bufWe) begin
      maskD[offQ] = 1'b1;
    end
  end

  // Correction only applies to units holding a valid code.
  always_comb begin
    readData = (memUsed[chkUnit] && !memDis[chkUnit]) ? fixedData : memData[chkUnit];
    rdDataD = rdDataQ;
    if (regRdStb) begin
      case (regAddr)
        fpp_pkg::REG_CTRL: rdDataD = {29'h0, ctrlQ};
        fpp_pkg::REG_STATUS: rdDataD = {25'h0, errQ, 4'h0, latchQ, busyQ};
        fpp_pkg::REG_CHK_ADDR: rdDataD = 32'(chkAddrQ);
        fpp_pkg::REG_CHK_STAT: begin
          rdDataD = 32'h0;
          rdDataD[fpp_pkg::CHK_DIS] = memDis[chkUnit];
          rdDataD[fpp_pkg::CHK_DATA_FIX] = memUsed[chkUnit] && !memDis[chkUnit] && dataFix;
          rdDataD[fpp_pkg::CHK_CODE_FIX] = memUsed[chkUnit] && !memDis[chkUnit] && codeFix;
          rdDataD[fpp_pkg::CHK_USED] = memUsed[chkUnit];
        end
        fpp_pkg::REG_DATA: rdDataD = {24'h0, readData[{chkAddrQ[3:0], 3'h0} +: 8]};
        default: rdDataD = 32'h0;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (bufWe) begin
      pageBuf[offQ[9:4]][{offQ[3:0], 3'h0} +: 8] <= lk.byteVal;
    end
    if (memWe) begin
      memData[memIdx] <= memDataD;
      memCode[memIdx] <= memCodeD;
      memDis[memIdx] <= memDisD;
      memUsed[memIdx] <= memUsedD;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      stateQ <= fpp_pkg::ST_OPCODE;
      opcQ <= 8'h00;
      addrQ <= 32'h0;
      addrCntQ <= 3'h0;
      offQ <= 10'h000;
      cntQ <= 2'h0;
      wideCmdQ <= 1'b0;
      wideQ <= 1'b0;
      latchQ <= 1'b0;
      errQ <= 1'b0;
      busyQ <= 1'b0;
      ctrlQ <= fpp_pkg::CTRL_RESET;
      chkAddrQ <= '0;
      unitQ <= '0;
      baseQ <= '0;
      rdDataQ <= 32'h0;
      maskQ <= '0;
    end else begin
      stateQ <= stateD;
      opcQ <= opcD;
      addrQ <= addrD;
      addrCntQ <= addrCntD;
      offQ <= offD;
      cntQ <= cntD;
      wideCmdQ <= wideCmdD;
      wideQ <= wideD;
      latchQ <= latchD;
      errQ <= errD;
      busyQ <= busyD;
      ctrlQ <= ctrlD;
      chkAddrQ <= chkAddrD;
      unitQ <= unitD;
      baseQ <= baseD;
      rdDataQ <= rdDataD;
      maskQ <= maskD;
    end
  end

  assign regRdData = rdDataQ;
  assign opInProgress = busyQ;

endmodule

// *** hdl/fpp_pkg.sv ***
package fpp_pkg;

  // Protected unit geometry.
  localparam int UNIT_BYTES = 16;
  localparam int UNIT_BITS = 128;
  localparam int CODE_BITS = 8;
  localparam logic [7:0] CODE_ERASED = 8'hff;

  // Page buffer options.
  localparam int PAGE_SMALL = 512;
  localparam int PAGE_LARGE = 1024;
  localparam logic [9:0] PAGE_MASK_SMALL = 10'h1ff;
  localparam logic [9:0] PAGE_MASK_LARGE = 10'h3ff;

  // Link opcodes.
  localparam logic [7:0] OPC_UNLOCK = 8'h06;
  localparam logic [7:0] OPC_SPW = 8'h02;
  localparam logic [7:0] OPC_SPW_WA = 8'h12;
  localparam logic [7:0] OPC_WPW_A = 8'h32;
  localparam logic [7:0] OPC_WPW_B = 8'h38;
  localparam logic [7:0] OPC_WPW_WA = 8'h34;

  // Register byte offsets.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CHK_ADDR = 8'h08;
  localparam logic [7:0] REG_CHK_STAT = 8'h0c;
  localparam logic [7:0] REG_DATA = 8'h10;
  localparam logic [7:0] REG_ERASE = 8'h14;

  // Control register fields and reset value.
  localparam int CTRL_LONG_ADDR = 0;
  localparam int CTRL_WIDE_EN = 1;
  localparam int CTRL_PAGE_LARGE = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  // Status register fields.
  localparam int STAT_BUSY = 0;
  localparam int STAT_UNLOCK = 1;
  localparam int STAT_PROG_ERR = 6;

  // Check status fields.
  localparam int CHK_DIS = 0;
  localparam int CHK_DATA_FIX = 1;
  localparam int CHK_CODE_FIX = 2;
  localparam int CHK_USED = 3;

  typedef enum logic [2:0] {
    ST_OPCODE,
    ST_ADDR,
    ST_DATA,
    ST_SKIP,
    ST_PROG,
    ST_ERASE
  } fpp_state_e;

endpackage

// *** tb/fpp_host_model.sv ***
`timescale 1ns/100ps
module fpp_host_model (
  // Link pins
  output logic sck,
  output logic csN,
  output logic [7:0] io
);
  // A 125 ns link period keeps wide loads well below the top link rate.
  localparam realtime HALF = 62.5;
  initial begin
    sck = 1'b0;
    csN = 1'b1;
    io = 8'h00;
  end
  // The first nSer bytes go serially on the lowest line, the rest whole on all eight.
  task automatic send(input logic [7:0] q[$], input int nSer);
    csN = 1'b0;
    foreach (q[i]) begin
      for (int b = 7; b >= 0; b--) begin
        if (i < nSer) begin
          io = {~io[7:1], q[i][b]};
        end else begin
          io = q[i];
        end
        #(HALF);
        sck = 1'b1;
        #(HALF);
        sck = 1'b0;
        if (i >= nSer) break;
      end
    end
    #(HALF);
    csN = 1'b1;
    io = ~io;
    #(2 * HALF);
  endtask
endmodule

// *** tb/fpp_page_program_monitor.sv ***
`timescale 1ns/100ps
module fpp_page_program_monitor (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Serial link pins
  input wire logic sck,
  input wire logic csN,
  input wire logic [7:0] io,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  input wire logic [31:0] regRdData,
  // Status
  input wire logic opInProgress
);
  int busyRun_d;
  int busyRun_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  always_comb begin
    busyRun_d = opInProgress ? busyRun_q + 1 : 0;
  end
  always_ff @(posedge ref_clk) begin
    busyRun_q <= rst_n ? busyRun_d : 0;
  end
  sequence wrAt(logic [7:0] a);
    regWrStb && regAddr == a;
  endsequence
  sequence rdAt(logic [7:0] a);
    regRdStb && regAddr == a;
  endsequence
  reset_clear_a: assert property (disable iff (1'b0) !rst_n |=> regRdData == 32'h0 && !opInProgress)
    else $error("outputs not cleared by reset");
  unmapped_read_a: assert property (regRdStb && regAddr > 8'h14 |=> regRdData == 32'h0)
    else $error("unmapped read not zero");
  read_hold_a: assert property (!regRdStb |=> $stable(regRdData))
    else $error("read data moved without a read");
  busy_status_a: assert property (rdAt(fpp_pkg::REG_STATUS) |=> regRdData[0] == $past(opInProgress))
    else $error("status busy bit differs from busy output");
  ctrl_readback_a: assert property (wrAt(fpp_pkg::REG_CTRL) ##1 rdAt(fpp_pkg::REG_CTRL)
    |=> regRdData[2:0] == $past(regWrData[2:0], 2))
    else $error("control readback differs");
  error_clear_a: assert property (wrAt(fpp_pkg::REG_STATUS) ##0 regWrData[6] ##1 rdAt(fpp_pkg::REG_STATUS)
    |=> !regRdData[6])
    else $error("program error not cleared");
  busy_from_idle_a: assert property ($rose(opInProgress) |-> csN)
    else $error("busy rose while selected");
  busy_length_a: assert property ($fell(opInProgress) |-> busyRun_q inside {[32:66]})
    else $error("busy span out of range");
endmodule

// *** tb/fpp_page_program_tb.sv ***
`timescale 1ns/100ps
module fpp_page_program_tb;
  logic ref_clk, rst_n, sck, csN, regWrStb, regRdStb, opInProgress;
  logic [7:0] io, regAddr;
  logic [31:0] regWrData, regRdData;
  int err_count = 0;
  int compares = 0;
  fpp_page_program #(.MEM_BYTES(4096), .SECTOR_BYTES(1024), .OTP_BYTES(256)) fpp_page_program_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .sck(sck), .csN(csN), .io(io), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
    .opInProgress(opInProgress));
  fpp_host_model fpp_host_model_inst (.sck(sck), .csN(csN), .io(io));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic results();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge ref_clk);
    regWrStb <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge ref_clk);
    regRdStb <= 1'b0;
    #1 chk($sformatf("reg %h", a), regRdData, e);
    @(posedge ref_clk);
  endtask
  // Write then read back in the very next cycle.
  task automatic wrChk(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge ref_clk);
    regWrStb <= 1'b0;
    regRdStb <= 1'b1;
    @(posedge ref_clk);
    regRdStb <= 1'b0;
    #1 chk($sformatf("back %h", a), regRdData, e);
    @(posedge ref_clk);
  endtask
  task automatic peek(input logic [11:0] a, input logic [7:0] d, input logic [3:0] st);
    wr(fpp_pkg::REG_CHK_ADDR, {20'h0, a});
    rc(fpp_pkg::REG_DATA, {24'h0, d});
    rc(fpp_pkg::REG_CHK_STAT, {28'h0, st});
  endtask
  task automatic frame(input logic [7:0] q[$], input int nSer);
    fpp_host_model_inst.send(q, nSer);
    @(posedge ref_clk);
  endtask
  task automatic unlock();
    frame('{fpp_pkg::OPC_UNLOCK}, 1);
  endtask
  // Busy is sampled mid-cycle so the edge's own updates have landed.
  task automatic done(input logic eb);
    logic seen;
    seen = 1'b0;
    repeat (20) begin
      @(negedge ref_clk);
      if (opInProgress === 1'b1) seen = 1'b1;
    end
    repeat (200) begin
      if (opInProgress !== 1'b0) @(negedge ref_clk);
    end
    chk("busy end", {31'h0, opInProgress}, 32'h0);
    @(posedge ref_clk);
    chk("busy seen", {31'h0, seen}, {31'h0, eb});
  endtask
  task automatic erase(input logic [31:0] s);
    unlock();
    wr(fpp_pkg::REG_ERASE, s);
    done(1'b1);
  endtask
  task automatic s_first();
    logic [7:0] q[$];
    q = '{fpp_pkg::OPC_SPW, 8'h00, 8'h00, 8'h10};
    for (int i = 0; i < 16; i++) q.push_back(8'h80 + 8'(i));
    unlock();
    frame(q, q.size());
    done(1'b1);
    peek(12'h010, 8'h80, 4'h8);
    peek(12'h01f, 8'h8f, 4'h8);
    peek(12'h020, 8'hff, 4'h0);
    rc(fpp_pkg::REG_STATUS, 32'h0);
  endtask
  task automatic s_reprog();
    frame('{fpp_pkg::OPC_SPW, 8'h00, 8'h00, 8'h40, 8'h00}, 5);
    done(1'b0);
    peek(12'h040, 8'hff, 4'h0);
    wrChk(fpp_pkg::REG_CTRL, 32'h1, 32'h1);
    unlock();
    frame('{fpp_pkg::OPC_SPW, 8'h00, 8'h00, 8'h00, 8'h13, 8'h03}, 6);
    done(1'b1);
    peek(12'h013, 8'h03, 4'h9);
    peek(12'h010, 8'h80, 4'h9);
    wrChk(fpp_pkg::REG_CTRL, 32'h0, 32'h0);
  endtask
  task automatic s_wrap();
    logic [7:0] q[$];
    q = '{fpp_pkg::OPC_SPW_WA, 8'h00, 8'h00, 8'h01, 8'hf8};
    for (int i = 0; i < 16; i++) q.push_back(8'h40 + 8'(i));
    unlock();
    frame(q, q.size());
    done(1'b1);
    peek(12'h1ff, 8'h47, 4'h8);
    peek(12'h000, 8'h48, 4'h8);
    peek(12'h008, 8'hff, 4'h8);
  endtask
  task automatic s_wide();
    logic [7:0] op[3] = '{fpp_pkg::OPC_WPW_A, fpp_pkg::OPC_WPW_B, fpp_pkg::OPC_WPW_WA};
    logic [7:0] hi[3] = '{8'h02, 8'h04, 8'h08};
    logic [7:0] q[$];
    unlock();
    frame('{op[0], 8'h00, 8'h02, 8'h00, 8'ha5, 8'h5a}, 4);
    done(1'b0);
    wrChk(fpp_pkg::REG_CTRL, 32'h2, 32'h2);
    for (int k = 0; k < 3; k++) begin
      q = '{op[k], 8'h00, hi[k], 8'h00, 8'ha5, 8'h5a};
      if (k == 2) q.insert(1, 8'h00);
      unlock();
      frame(q, (k == 2) ? 5 : 4);
      done(1'b1);
      peek({hi[k][3:0], 8'h00}, 8'ha5, 4'h8);
      peek({hi[k][3:0], 8'h01}, 8'h5a, 4'h8);
      peek({hi[k][3:0], 8'hf0}, 8'hff, 4'h8);
    end
    unlock();
    frame('{op[0], 8'h00, 8'h06, 8'h00, 8'h3c}, 4);
    done(1'b0);
    rc(fpp_pkg::REG_STATUS, 32'h2);
    wrChk(fpp_pkg::REG_CTRL, 32'h0, 32'h0);
  endtask
  task automatic s_error();
    frame('{fpp_pkg::OPC_SPW, 8'h00, 8'h10, 8'h00, 8'h00}, 5);
    repeat (20) @(posedge ref_clk);
    rc(fpp_pkg::REG_STATUS, 32'h40);
    wrChk(fpp_pkg::REG_STATUS, 32'h40, 32'h0);
  endtask
  initial begin
    #600us;
    err_count++;
    results();
  end
  initial begin
    rst_n = 1'b0;
    regAddr = 8'h00;
    regWrData = 32'h0;
    regWrStb = 1'b0;
    regRdStb = 1'b0;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
    rc(fpp_pkg::REG_CTRL, 32'h0);
    rc(fpp_pkg::REG_STATUS, 32'h0);
    rc(8'h40, 32'h0);
    for (int s = 0; s < 3; s++) erase(s);
    peek(12'h000, 8'hff, 4'h0);
    s_first();
    s_reprog();
    s_wrap();
    s_wide();
    s_error();
    erase(0);
    peek(12'h013, 8'hff, 4'h0);
    results();
  end
endmodule
bind fpp_page_program fpp_page_program_monitor fpp_page_program_monitor_inst (
  .ref_clk(ref_clk), .rst_n(rst_n), .sck(sck), .csN(csN), .io(io), .regAddr(regAddr),
  .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
  .opInProgress(opInProgress));
